/* rtl/shadowed_status_config_regs.sv */
// Shadowed status and configuration register bank with non-volatile backing
// Notes on behaviour
// - Status and config registers each exist as a non-volatile and a volatile copy.
// - Read-any of a dual register returns the non-volatile or volatile copy chosen by the address.
// - Power-on, hardware and software reset copy non-volatile into volatile.
// - Non-volatile write erases, programs, then refreshes the volatile copy.
// - One-time bits program non-volatile and update only those volatile bits.
// - Volatile copies reload from non-volatile on every reset; non-volatile bits keep their programmed value through hardware and software reset.
// - Legacy write 01h, write-any 71h, read-any 65h are decoded.
// - Lock bit set with protect pin low blocks all status/config writes.
// - Lock bit clear lets writes through whatever the protect pin level.
// - Bits 6 and 5 are read-only error defaults, shipped zero.
// - Bits 4:2 hold non-volatile protection, used while select bit 3 is 0.
// - Selecting volatile protection programs the non-volatile field to 111b, then locks it.
// - Volatile lock bit copies the non-volatile lock bit after each change.
// - In non-volatile protection mode legacy write sets both protection fields.
`timescale 1ns/1ps
module shadowed_status_config_regs #(
   parameter int ERASE_CYCLES = shadow_regs_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES = shadow_regs_pkg::PROG_CYCLES
) (
   // Clock and resets
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic hw_reset_n_i,
   input wire logic sw_reset_i,
   // Register command port
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_opcode_i,
   input wire logic [23:0] cmd_addr_i,
   input wire logic [7:0] cmd_wdata_i,
   input wire logic cmd_cfg_present_i,
   input wire logic [7:0] cmd_cfg_wdata_i,
   // Status events
   input wire logic prog_error_i,
   input wire logic erase_error_i,
   input wire logic clear_status_i,
   input wire logic write_enable_i,
   input wire logic write_disable_i,
   // Write protect pin
   input wire logic write_protect_n_i,
   // Read answer
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic cmd_refused_o,
   // Register state
   output logic busy_o,
   output logic [7:0] status_one_volatile_o,
   output logic [7:0] config_one_volatile_o,
   output logic [2:0] block_protect_o
);
   import shadow_regs_pkg::*;

   // =========================================================
   // Reset and pin synchronisers
   logic [1:0] rst_sync_q, hw_sync_q, wp_sync_q;
   logic rst_n;
   // Power-on reset release
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];
   // Pin inputs pass two flops
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         {hw_sync_q, wp_sync_q} <= 4'hF;
      else
         {hw_sync_q, wp_sync_q} <= {hw_sync_q[0], hw_reset_n_i, wp_sync_q[0], write_protect_n_i};
   end

   // =========================================================
   // Non-volatile store, status in low byte, config in high byte
   logic nv_start, nv_busy, nv_done;
   logic [15:0] nv_wdata, nv_data;
   logic [7:0] status_nv, config_nv;

   nv_cell_store #(
      .ERASE_CYCLES(ERASE_CYCLES),
      .PROG_CYCLES(PROG_CYCLES),
      .FACTORY({CONFIG_NV_RESET, STATUS_NV_RESET})
   ) u_nv (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .start_i(nv_start),
      .wdata_i(nv_wdata),
      .busy_o(nv_busy),
      .done_o(nv_done),
      .data_o(nv_data)
   );
   assign status_nv = nv_data[7:0];
   assign config_nv = nv_data[15:8];

   // Merge a write into one-time bits (only set) and plain bits
   function automatic logic [7:0] merge_config(input logic [7:0] old_v, input logic [7:0] new_v);
      merge_config = (new_v & ~CONFIG_OTP_MASK) | ((old_v | new_v) & CONFIG_OTP_MASK);
   endfunction : merge_config
   // Compute new non-volatile status from a host byte
   function automatic logic [7:0] merge_status(input logic [7:0] old_v, input logic [7:0] new_v,
                                                input logic bp_vol);
      logic [7:0] m;
      m = bp_vol ? STATUS_LOCK_MASK : (STATUS_LOCK_MASK | STATUS_BP_MASK);
      merge_status = (old_v & ~m) | (new_v & m);
   endfunction : merge_status
   // =========================================================
   // Command sequencer and volatile registers
   seq_state_t state_q, state_d;
   logic [7:0] status_v_q, status_v_d, config_v_q, config_v_d;
   logic [7:0] otp_new_q, otp_new_d, rd_data_q, rd_data_d;
   logic rd_valid_q, rd_valid_d, refused_q, refused_d;
   logic any_reset, locked, bp_vol_mode, is_write, legacy_wr;
   logic [7:0] new_status, new_config, status_read;
   assign any_reset = ~hw_sync_q[1] | sw_reset_i;
   assign locked = status_nv[LOCK_BIT] & ~wp_sync_q[1];
   assign bp_vol_mode = config_nv[CFG_BP_SEL_BIT];
   assign legacy_wr = cmd_valid_i && (cmd_opcode_i == OPC_LEGACY_WRITE);
   assign is_write = legacy_wr || (cmd_valid_i && (cmd_opcode_i == OPC_WRITE_ANY));
   assign status_read = {status_v_q[7:1], status_v_q[WIP_BIT] | nv_busy};

   always_comb
   begin
      state_d = state_q;
      status_v_d = status_v_q;
      config_v_d = config_v_q;
      otp_new_d = otp_new_q;
      rd_data_d = rd_data_q;
      rd_valid_d = 1'b0;
      refused_d = 1'b0;
      nv_start = 1'b0;
      new_status = status_nv;
      new_config = config_nv;
      // Non-volatile target values of a write
      if (legacy_wr || cmd_addr_i == ADDR_STATUS_NV)
         new_status = merge_status(status_nv, cmd_wdata_i, bp_vol_mode);
      if ((legacy_wr && cmd_cfg_present_i) || (!legacy_wr && cmd_addr_i == ADDR_CONFIG_NV))
         new_config = merge_config(config_nv, legacy_wr ? cmd_cfg_wdata_i : cmd_wdata_i);
      if (new_config[CFG_BP_SEL_BIT] && !bp_vol_mode)
         new_status[BP_MSB:BP_LSB] = BP_LOCKED;
      nv_wdata = {new_config, new_status};
      // Read any register returns the non-volatile or volatile copy selected by the address
      if (cmd_valid_i && cmd_opcode_i == OPC_READ_ANY)
      begin
         rd_valid_d = 1'b1;
         case (cmd_addr_i)
            ADDR_STATUS_NV: rd_data_d = status_nv;
            ADDR_CONFIG_NV: rd_data_d = config_nv;
            ADDR_STATUS_V: rd_data_d = status_read;
            ADDR_CONFIG_V: rd_data_d = config_v_q;
            default: rd_data_d = 8'h00;
         endcase
      end
      // Write handling, any write while busy is refused
      if (is_write && state_q != ST_IDLE)
         refused_d = 1'b1;
      case (state_q)
         ST_IDLE:
         begin
            if (is_write && locked)
               refused_d = 1'b1;
            else if (is_write && !legacy_wr && cmd_addr_i == ADDR_STATUS_V)
            begin
               if (bp_vol_mode)
                  status_v_d[BP_MSB:BP_LSB] = cmd_wdata_i[BP_MSB:BP_LSB];
            end
            else if (is_write && !legacy_wr && cmd_addr_i == ADDR_CONFIG_V)
               config_v_d = (cmd_wdata_i & ~CONFIG_OTP_MASK) | (config_v_q & CONFIG_OTP_MASK);
            else if (is_write)
            begin
               if (legacy_wr && bp_vol_mode)
                  status_v_d[BP_MSB:BP_LSB] = cmd_wdata_i[BP_MSB:BP_LSB];
               if (nv_wdata != nv_data)
               begin
                  nv_start = 1'b1;
                  otp_new_d = new_config & ~config_nv & CONFIG_OTP_MASK;
                  state_d = ST_UPDATE;
               end
            end
         end
         ST_UPDATE:
         begin
            if (nv_done)
               state_d = ST_REFRESH;
         end
         ST_REFRESH:
         begin
            status_v_d[LOCK_BIT] = status_nv[LOCK_BIT];
            if (!bp_vol_mode)
               status_v_d[BP_MSB:BP_LSB] = status_nv[BP_MSB:BP_LSB];
            config_v_d = (config_nv & ~CONFIG_OTP_MASK) | (config_v_q & CONFIG_OTP_MASK)
                         | (config_nv & otp_new_q);
            state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
      // Runtime flags, the set wins over the clear
      status_v_d[PERR_BIT] = prog_error_i | (status_v_d[PERR_BIT] & ~clear_status_i);
      status_v_d[EERR_BIT] = erase_error_i | (status_v_d[EERR_BIT] & ~clear_status_i);
      status_v_d[WEL_BIT] = write_enable_i | (status_v_d[WEL_BIT] & ~write_disable_i);
      // Any reset reloads volatile copies from non-volatile
      if (any_reset)
      begin
         status_v_d = status_nv;
         config_v_d = config_nv;
      end
   end

   // Power-on reset loads volatile copies with the factory values
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         status_v_q <= STATUS_NV_RESET;
         config_v_q <= CONFIG_NV_RESET;
         otp_new_q <= 8'h00;
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
         refused_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         status_v_q <= status_v_d;
         config_v_q <= config_v_d;
         otp_new_q <= otp_new_d;
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
         refused_q <= refused_d;
      end
   end

   // Outputs
   assign rd_valid_o = rd_valid_q;
   assign rd_data_o = rd_data_q;
   assign cmd_refused_o = refused_q;
   assign busy_o = (state_q != ST_IDLE);
   assign status_one_volatile_o = status_read;
   assign config_one_volatile_o = config_v_q;
   assign block_protect_o = bp_vol_mode ? status_v_q[BP_MSB:BP_LSB]
                                        : status_nv[BP_MSB:BP_LSB];

   // =========================================================
   // Assertions
   property p_read_volatile;
      @(posedge clk_i) disable iff (!rst_n)
      (cmd_valid_i && cmd_opcode_i == OPC_READ_ANY && cmd_addr_i == ADDR_CONFIG_V)
      |=> rd_valid_o && rd_data_o == $past(config_v_q);
   endproperty
   a_read_volatile: assert property (p_read_volatile) else $error("volatile read wrong");
   property p_reset_copy;
      @(posedge clk_i) disable iff (!rst_n)
      sw_reset_i |=> status_v_q == $past(status_nv) && config_v_q == $past(config_nv);
   endproperty
   a_reset_copy: assert property (p_reset_copy) else $error("reset copy missing");
   property p_nv_kept;
      @(posedge clk_i) disable iff (!rst_n)
      (any_reset && !nv_busy) |=> $stable(nv_data);
   endproperty
   a_nv_kept: assert property (p_nv_kept) else $error("reset changed non-volatile");
   property p_lock_blocks;
      @(posedge clk_i) disable iff (!rst_n)
      (is_write && locked) |-> !nv_start ##1 cmd_refused_o;
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("locked write executed");
   property p_unlocked_write;
      @(posedge clk_i) disable iff (!rst_n)
      (legacy_wr && state_q == ST_IDLE && !status_nv[LOCK_BIT]
       && cmd_wdata_i[LOCK_BIT]) |-> nv_start;
   endproperty
   a_unlocked_write: assert property (p_unlocked_write) else $error("write not started");
   property p_err_defaults;
      @(posedge clk_i) disable iff (!rst_n)
      !nv_busy |-> status_nv[PERR_BIT:EERR_BIT] == 2'b00;
   endproperty
   a_err_defaults: assert property (p_err_defaults) else $error("error defaults changed");
   property p_bp_locked;
      @(posedge clk_i) disable iff (!rst_n)
      (!nv_busy && bp_vol_mode) |-> status_nv[BP_MSB:BP_LSB] == BP_LOCKED;
   endproperty
   a_bp_locked: assert property (p_bp_locked) else $error("protection field not 111b");
   property p_lock_copy;
      @(posedge clk_i) disable iff (!rst_n)
      (nv_done && !any_reset) |=> ##1 status_v_q[LOCK_BIT] == status_nv[LOCK_BIT];
   endproperty
   a_lock_copy: assert property (p_lock_copy) else $error("lock copy stale");
   property p_no_early_refresh;
      @(posedge clk_i) disable iff (!rst_n)
      (state_q == ST_UPDATE && !any_reset) |=> $stable(status_v_q[LOCK_BIT]);
   endproperty
   a_no_early_refresh: assert property (p_no_early_refresh) else $error("early refresh");

endmodule : shadowed_status_config_regs

/* rtl/shadow_regs_pkg.sv */
// Shared constants for the shadowed status and configuration register bank
package shadow_regs_pkg;

   // =========================================================
   // Clock and non-volatile cell timing
   localparam int CLK_MHZ = 125;
   localparam int ERASE_TIME_NS = 400;
   localparam int PROG_TIME_NS = 200;
   localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

   // =========================================================
   // Instruction codes
   localparam logic [7:0] OPC_LEGACY_WRITE = 8'h01;
   localparam logic [7:0] OPC_READ_ANY = 8'h65;
   localparam logic [7:0] OPC_WRITE_ANY = 8'h71;

   // =========================================================
   // Register addresses for the any-register commands
   localparam logic [23:0] ADDR_STATUS_NV = 24'h000000;
   localparam logic [23:0] ADDR_CONFIG_NV = 24'h000002;
   localparam logic [23:0] ADDR_STATUS_V = 24'h800000;
   localparam logic [23:0] ADDR_CONFIG_V = 24'h800002;

   // =========================================================
   // Field positions
   localparam int LOCK_BIT = 7;
   localparam int PERR_BIT = 6;
   localparam int EERR_BIT = 5;
   localparam int BP_MSB = 4;
   localparam int BP_LSB = 2;
   localparam int WEL_BIT = 1;
   localparam int WIP_BIT = 0;
   localparam int CFG_BP_SEL_BIT = 3;

   // =========================================================
   // Factory values and masks
   localparam logic [7:0] STATUS_NV_RESET = 8'h00;
   localparam logic [7:0] CONFIG_NV_RESET = 8'h00;
   localparam logic [2:0] BP_LOCKED = 3'h7;
   localparam logic [7:0] STATUS_LOCK_MASK = 8'h80;
   localparam logic [7:0] STATUS_BP_MASK = 8'h1C;
   localparam logic [7:0] CONFIG_OTP_MASK = 8'h08;

   // =========================================================
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_UPDATE = 2'b01,
      ST_REFRESH = 2'b10
   } seq_state_t;

   typedef enum logic [1:0]
   {
      NV_IDLE = 2'b00,
      NV_ERASE = 2'b01,
      NV_PROG = 2'b10
   } nv_state_t;

endpackage : shadow_regs_pkg

/* rtl/nv_cell_store.sv */
// Non-volatile cell store: erase to ones, then program the new word
`timescale 1ns/1ps
module nv_cell_store #(
   parameter int ERASE_CYCLES = shadow_regs_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES = shadow_regs_pkg::PROG_CYCLES,
   parameter logic [15:0] FACTORY = 16'h0000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Update request
   input wire logic start_i,
   input wire logic [15:0] wdata_i,
   // Status and contents
   output logic busy_o,
   output logic done_o,
   output logic [15:0] data_o
);
   import shadow_regs_pkg::*;

   initial
   begin
      if (ERASE_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES > 65535 || PROG_CYCLES > 65535)
         $error("nv_cell_store: cycle counts out of range");
   end

   nv_state_t state_q, state_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] data_q, data_d;
   logic [15:0] wbuf_q, wbuf_d;
   logic done_q, done_d;

   // Next state of erase and program sequence
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      data_d = data_q;
      wbuf_d = wbuf_q;
      done_d = 1'b0;
      case (state_q)
         NV_IDLE:
         begin
            if (start_i)
            begin
               wbuf_d = wdata_i;
               cnt_d = 16'(ERASE_CYCLES - 1);
               state_d = NV_ERASE;
            end
         end
         NV_ERASE:
         begin
            if (cnt_q == 16'h0000)
            begin
               data_d = 16'hFFFF; // Erased cells read as ones
               cnt_d = 16'(PROG_CYCLES - 1);
               state_d = NV_PROG;
            end
            else
               cnt_d = cnt_q - 16'h0001;
         end
         NV_PROG:
         begin
            if (cnt_q == 16'h0000)
            begin
               data_d = data_q & wbuf_q; // Programming only clears bits
               done_d = 1'b1;
               state_d = NV_IDLE;
            end
            else
               cnt_d = cnt_q - 16'h0001;
         end
         default:
            state_d = NV_IDLE;
      endcase
   end

   // Cell contents survive everything except power-on
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= NV_IDLE;
         cnt_q <= 16'h0000;
         data_q <= FACTORY;
         wbuf_q <= 16'h0000;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         data_q <= data_d;
         wbuf_q <= wbuf_d;
         done_q <= done_d;
      end
   end

   assign busy_o = (state_q != NV_IDLE);
   assign done_o = done_q;
   assign data_o = data_q;

endmodule : nv_cell_store

/* verif/host_cmd_model.sv */
// Host controller model issuing register commands to the bank
`timescale 1ns/1ps
module host_cmd_model (
   // Clock
   input wire logic clk_i,
   // Command outputs
   output logic cmd_valid_o,
   output logic [7:0] cmd_opcode_o,
   output logic [23:0] cmd_addr_o,
   output logic [7:0] cmd_wdata_o,
   output logic cmd_cfg_present_o,
   output logic [7:0] cmd_cfg_wdata_o,
   // Answers
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   input wire logic cmd_refused_i
);
   // ==========================================
   // Idle command port
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_opcode_o = 8'hFF;
      cmd_addr_o = 24'hFFFFFF;
      cmd_wdata_o = 8'hFF;
      cmd_cfg_present_o = 1'b0;
      cmd_cfg_wdata_o = 8'hFF;
   end

   // One command, one cycle wide, answer taken one cycle later
   task automatic issue(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] wd,
                        input logic cfg_en, input logic [7:0] cfg,
                        output logic rv, output logic [7:0] rd, output logic rf);
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_opcode_o = op;
      cmd_addr_o = addr;
      cmd_wdata_o = wd;
      cmd_cfg_present_o = cfg_en;
      cmd_cfg_wdata_o = cfg;
      @(negedge clk_i);
      rv = rd_valid_i;
      rd = rd_data_i;
      rf = cmd_refused_i;
      // Released fields carry no stale value
      cmd_valid_o = 1'b0;
      cmd_opcode_o = ~op;
      cmd_addr_o = ~addr;
      cmd_wdata_o = ~wd;
      cmd_cfg_present_o = ~cfg_en;
      cmd_cfg_wdata_o = ~cfg;
   endtask : issue
endmodule : host_cmd_model

/* verif/tb_top.sv */
// Self-checking bench for the shadowed register bank
`timescale 1ns/1ps
module tb_top;
   import shadow_regs_pkg::*;
   logic clk_i, reset_n_i, hw_reset_n_i, sw_reset_i, wp_n;
   logic prog_err, erase_err, clr_st, wr_en, wr_dis;
   logic cv, ccp, rv, rf, busy, rv_s, rf_s;
   logic [7:0] cop, cwd, ccfg, rdat, st_v, cf_v, rd_s;
   logic [23:0] cad;
   logic [2:0] bp;
   int failures = 0;
   int checked = 0;
   typedef struct {logic [7:0] op; logic [23:0] addr; logic rv; logic [7:0] data;} row_t;
   row_t rows [6];

   // ==========================================
   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ==========================================
   // Design and host model
   shadowed_status_config_regs #(.ERASE_CYCLES(2), .PROG_CYCLES(2)) DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .hw_reset_n_i(hw_reset_n_i),
      .sw_reset_i(sw_reset_i), .cmd_valid_i(cv), .cmd_opcode_i(cop), .cmd_addr_i(cad),
      .cmd_wdata_i(cwd), .cmd_cfg_present_i(ccp), .cmd_cfg_wdata_i(ccfg),
      .prog_error_i(prog_err), .erase_error_i(erase_err), .clear_status_i(clr_st),
      .write_enable_i(wr_en), .write_disable_i(wr_dis), .write_protect_n_i(wp_n),
      .rd_valid_o(rv), .rd_data_o(rdat), .cmd_refused_o(rf), .busy_o(busy),
      .status_one_volatile_o(st_v), .config_one_volatile_o(cf_v), .block_protect_o(bp));
   host_cmd_model host (
      .clk_i(clk_i), .cmd_valid_o(cv), .cmd_opcode_o(cop), .cmd_addr_o(cad),
      .cmd_wdata_o(cwd), .cmd_cfg_present_o(ccp), .cmd_cfg_wdata_o(ccfg),
      .rd_valid_i(rv), .rd_data_i(rdat), .cmd_refused_i(rf));

   // ==========================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                      input logic ce, input logic [7:0] c);
      host.issue(op, a, d, ce, c, rv_s, rd_s, rf_s);
   endtask : cmd

   task automatic read_reg(input logic [23:0] a, input logic [7:0] m, input logic [7:0] exp);
      cmd(OPC_READ_ANY, a, 8'h00, 1'b0, 8'h00);
      check({7'h00, rv_s}, 8'h01);
      check(rd_s & m, exp);
   endtask : read_reg

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 300)
      begin
         @(negedge clk_i);
         n++;
      end
      if (busy !== 1'b0)
      begin
         failures++;
         $display("Error at %0t: busy never cleared", $time);
         complete_run();
      end
   endtask : wait_idle

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cycles

   // ==========================================
   // Main sequence
   initial
   begin
      {prog_err, erase_err, clr_st, wr_en, wr_dis, sw_reset_i} = 6'h00;
      reset_n_i = 1'b0;
      hw_reset_n_i = 1'b1;
      wp_n = 1'b1;
      rows = '{'{OPC_READ_ANY, ADDR_STATUS_NV, 1'b1, 8'h00},
               '{OPC_READ_ANY, ADDR_CONFIG_NV, 1'b1, 8'h00},
               '{OPC_READ_ANY, ADDR_STATUS_V, 1'b1, 8'h00},
               '{OPC_READ_ANY, ADDR_CONFIG_V, 1'b1, 8'h00},
               '{OPC_READ_ANY, 24'h000004, 1'b1, 8'h00},
               '{8'h00, ADDR_STATUS_V, 1'b0, 8'h00}};
      cycles(20);
      reset_n_i = 1'b1;
      cycles(4);
      // Factory state after power-on
      foreach (rows[i])
      begin
         cmd(rows[i].op, rows[i].addr, 8'h00, 1'b0, 8'h00);
         check({7'h00, rv_s}, {7'h00, rows[i].rv});
         if (rows[i].rv)
            check(rd_s, rows[i].data);
      end
      $display("Table test done");
      // Legacy write, old copy during update, write while busy refused
      cmd(OPC_LEGACY_WRITE, 24'h000000, 8'hFC, 1'b0, 8'h00);
      check({7'h00, busy}, 8'h01);
      read_reg(ADDR_STATUS_V, 8'hFC, 8'h00);
      cmd(OPC_WRITE_ANY, ADDR_STATUS_NV, 8'h00, 1'b0, 8'h00);
      check({7'h00, rf_s}, 8'h01);
      wait_idle();
      read_reg(ADDR_STATUS_V, 8'hFF, 8'h9C);
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h9C);
      check({5'h00, bp}, 8'h07);
      $display("Update test done");
      // Lock with protect pin low
      wp_n = 1'b0;
      cycles(3);
      cmd(OPC_LEGACY_WRITE, 24'h000000, 8'h00, 1'b0, 8'h00);
      check({6'h00, rf_s, busy}, 8'h02);
      cmd(OPC_WRITE_ANY, ADDR_CONFIG_V, 8'h00, 1'b0, 8'h00);
      check({7'h00, rf_s}, 8'h01);
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h9C);
      // Pin high lets write through, then lock clear ignores pin
      wp_n = 1'b1;
      cycles(3);
      cmd(OPC_WRITE_ANY, ADDR_STATUS_NV, 8'h00, 1'b0, 8'h00);
      check({7'h00, rf_s}, 8'h00);
      wait_idle();
      read_reg(ADDR_STATUS_V, 8'hFF, 8'h00);
      wp_n = 1'b0;
      cycles(3);
      cmd(OPC_LEGACY_WRITE, 24'h000000, 8'h04, 1'b0, 8'h00);
      check({7'h00, rf_s}, 8'h00);
      wait_idle();
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h04);
      check({5'h00, bp}, 8'h01);
      wp_n = 1'b1;
      $display("Lock test done");
      // Runtime flags and the two resets
      prog_err = 1'b1;
      wr_en = 1'b1;
      cycles(1);
      {prog_err, wr_en} = 2'b00;
      cycles(1);
      check(st_v, 8'h46);
      {clr_st, wr_dis, erase_err} = 3'b111;
      cycles(1);
      {clr_st, wr_dis, erase_err} = 3'b000;
      cycles(1);
      check(st_v, 8'h24);
      sw_reset_i = 1'b1;
      cycles(1);
      sw_reset_i = 1'b0;
      cycles(1);
      check(st_v, 8'h04);
      prog_err = 1'b1;
      cycles(1);
      prog_err = 1'b0;
      hw_reset_n_i = 1'b0;
      cycles(4);
      hw_reset_n_i = 1'b1;
      cycles(4);
      check(st_v, 8'h04);
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h04);
      $display("Reset test done");
      // Selecting volatile protection fixes the stored field
      cmd(OPC_LEGACY_WRITE, 24'h000000, 8'h04, 1'b1, 8'h08);
      wait_idle();
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h1C);
      read_reg(ADDR_CONFIG_NV, 8'hFF, 8'h08);
      check(cf_v & CONFIG_OTP_MASK, 8'h08);
      cmd(OPC_LEGACY_WRITE, 24'h000000, 8'h00, 1'b1, 8'h08);
      cycles(1);
      wait_idle();
      read_reg(ADDR_STATUS_NV, 8'hFF, 8'h1C);
      cmd(OPC_WRITE_ANY, ADDR_STATUS_V, 8'h08, 1'b0, 8'h00);
      cycles(1);
      wait_idle();
      check({5'h00, bp}, 8'h02);
      cmd(OPC_WRITE_ANY, ADDR_CONFIG_V, 8'h00, 1'b0, 8'h00);
      check(cf_v, 8'h08);
      $display("Protection select test done");
      complete_run();
   end
endmodule : tb_top
